// file: hdl/mlsd_decoder.sv
// Summary of operation
// - Base instructions of 16 and 24 bits are accepted and reported.
// - Extension instructions of 24, 32 and 64 bits are accepted and reported.
// - Length comes only from the instruction's own bits; there is no size mode.
// - Any mix of lengths may follow back to back in the fetched byte stream.
// - Wide words are split into slots each carrying an independent operation.
// - Slot boundaries are set per format and slots may differ in width.
// - Any slot combination is legal if each slot's operation is in that slot's set.
// - In custom operations state registers are named by the opcode and take no operand bits; moves name them in the SIDX field.
// - Each state has a move to the general registers and a move back from them.
// - A custom operation drives the address on which the load/store unit acts.
// - Custom load data returns on the 32-bit load return data input.
// - Custom store data is driven on the store write data output.
`timescale 1ns/1ps
module mlsd_decoder (
    input  wire logic                                      CLK,
    input  wire logic                                      SYS_RST,
    input  wire logic                                      FETCH_VALID,
    input  wire logic [7:0]                                FETCH_BYTE,
    output logic                                           FETCH_READY,
    output logic                                           INSN_VALID,
    output logic [1:0]                                     INSN_LEN,
    output logic [63:0]                                    INSN_WORD,
    output logic                                           INSN_ILLEGAL,
    output logic [mlsd_pkg::NUM_SLOTS-1:0]                 SLOT_VALID,
    output logic [mlsd_pkg::NUM_SLOTS-1:0][3:0]            SLOT_OP,
    output logic [3:0]                                     GR_RD_IDX,
    input  wire logic [31:0]                               GR_RD_DATA,
    output logic                                           GR_WR_EN,
    output logic [3:0]                                     GR_WR_IDX,
    output logic [31:0]                                    GR_WR_DATA,
    output logic                                           LS_REQ,
    output logic                                           LS_WRITE,
    output logic [31:0]                                    LOAD_STORE_VIRTUAL_ADDRESS,
    output logic [31:0]                                    STORE_WRITE_DATA,
    input  wire logic                                      LOAD_RETURN_VALID,
    input  wire logic [31:0]                               LOAD_RETURN_DATA
);
    import mlsd_pkg::*;

    // ------------------------------------------------------------
    // State bank
    // ------------------------------------------------------------
    mlsd_state_if sif ();

    mlsd_state_bank u_bank (
        .clk (CLK),
        .rst (SYS_RST),
        .sif (sif)
    );

    mlsd_ctl_t r_ff;
    mlsd_ctl_t nxt_r;

    // ------------------------------------------------------------
    // Byte assembly and early length
    // ------------------------------------------------------------
    logic        first_byte;
    logic [63:0] asm_word;
    logic [3:0]  need_bytes;
    logic [1:0]  len_code;
    logic        word_done;

    assign first_byte = (r_ff.cnt == 4'h0);
    // Shift by byte count; little-endian, byte 0 holds the length code
    assign asm_word   = first_byte ? {56'h0, FETCH_BYTE}
                      : (r_ff.word | (64'(FETCH_BYTE) << {r_ff.cnt[2:0], 3'b000}));
    assign len_code   = first_byte ? FETCH_BYTE[LEN_LO +: 2] : r_ff.len;
    assign need_bytes = first_byte ? mlsd_len_bytes(len_code) : r_ff.need;
    assign word_done  = FETCH_VALID && r_ff.fetch_ready && ((r_ff.cnt + 4'h1) == need_bytes);

    // ------------------------------------------------------------
    // Slot extraction for the wide formats
    // ------------------------------------------------------------
    logic [NUM_SLOTS-1:0][3:0] slot_op_w;
    logic [NUM_SLOTS-1:0]      slot_ok_w;
    logic                      wide_fmt;

    assign wide_fmt = (len_code == LEN_32) || (len_code == LEN_64);

    generate
        for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
            logic [3:0] op64;
            logic [3:0] op32;
            assign op64 = asm_word[SLOT64_LO[s] +: 4];
            if (s < 2) begin : g_in32
                assign op32 = asm_word[SLOT32_LO[s] +: 4];
            end else begin : g_pad32
                assign op32 = OP_NOP;
            end
            assign slot_op_w[s] = (len_code == LEN_64) ? op64 : op32;
            // Each slot checks only its own set, so any mix of legal ops passes
            assign slot_ok_w[s] = (len_code == LEN_64) ? SLOT64_MASK[s][op64]
                                                       : SLOT32_MASK[s][op32];
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic [3:0] op24;
    logic [2:0] sidx24;
    logic [3:0] gri24;
    logic       sidx_ok;

    assign op24    = asm_word[OP_LO +: 4];
    assign sidx24  = asm_word[SIDX_LO +: 3];
    assign gri24   = asm_word[GR_LO +: 4];
    assign sidx_ok = (asm_word[SIDX_LO + 3] == 1'b0) && (sidx24 < 3'(NUM_STATES));

    always_comb begin
        nxt_r            = r_ff;
        nxt_r.insn_valid = 1'b0;
        nxt_r.gr_wr_en   = 1'b0;
        nxt_r.ls_req     = 1'b0;
        sif.wr_en        = '0;
        sif.wr_data      = sif.rd_data;
        case (r_ff.fsm)
            FSM_FETCH: begin
                nxt_r.fetch_ready = 1'b1;
                if (FETCH_VALID && r_ff.fetch_ready) begin
                    nxt_r.word = asm_word;
                    nxt_r.len  = len_code;
                    nxt_r.need = need_bytes;
                    nxt_r.cnt  = r_ff.cnt + 4'h1;
                end
                if (word_done) begin
                    // Boundary reached; next byte starts a fresh word
                    nxt_r.cnt          = 4'h0;
                    nxt_r.insn_valid   = 1'b1;
                    nxt_r.insn_word    = asm_word;
                    nxt_r.slot_valid   = '0;
                    nxt_r.slot_op      = '0;
                    nxt_r.insn_illegal = 1'b0;
                    if (wide_fmt) begin
                        nxt_r.slot_op = slot_op_w;
                        for (int s = 0; s < NUM_SLOTS; s++) begin
                            // Nop slots raise no valid, so nothing downstream acts
                            nxt_r.slot_valid[s] = (slot_op_w[s] != OP_NOP);
                        end
                        nxt_r.insn_illegal = ~&slot_ok_w;
                    end else if (len_code == LEN_24) begin
                        case (op24)
                            OP_READ_STATE: begin
                                if (sidx_ok) begin
                                    nxt_r.gr_wr_en   = 1'b1;
                                    nxt_r.gr_wr_idx  = gri24;
                                    nxt_r.gr_wr_data = sif.rd_data[sidx24];
                                end else begin
                                    nxt_r.insn_illegal = 1'b1;
                                end
                            end
                            OP_WRITE_STATE: begin
                                if (sidx_ok) begin
                                    nxt_r.gr_rd_idx   = gri24;
                                    nxt_r.sidx        = sidx24;
                                    nxt_r.fetch_ready = 1'b0;
                                    nxt_r.fsm         = FSM_GR_READ;
                                end else begin
                                    nxt_r.insn_illegal = 1'b1;
                                end
                            end
                            OP_INST1: begin
                                // Operands fixed by the opcode alone
                                nxt_r.ls_req      = 1'b1;
                                nxt_r.ls_write    = 1'b0;
                                nxt_r.ls_addr     = sif.rd_data[ST9];
                                sif.wr_en[ST9]    = 1'b1;
                                sif.wr_data[ST9]  = sif.rd_data[ST9] + ADDR_STEP;
                                sif.wr_en[ST12]   = 1'b1;
                                sif.wr_data[ST12] = sif.rd_data[ST10] + sif.rd_data[ST8];
                                nxt_r.load_dst    = ST8;
                                nxt_r.fetch_ready = 1'b0;
                                nxt_r.fsm         = FSM_LOAD_WAIT;
                            end
                            OP_INST2: begin
                                nxt_r.ls_req      = 1'b1;
                                nxt_r.ls_write    = 1'b0;
                                nxt_r.ls_addr     = sif.rd_data[ST11];
                                sif.wr_en[ST11]   = 1'b1;
                                sif.wr_data[ST11] = sif.rd_data[ST11] + ADDR_STEP;
                                sif.wr_en[ST12]   = 1'b1;
                                sif.wr_data[ST12] = {17'h0, sif.rd_data[ST12][15:1]};
                                nxt_r.load_dst    = ST10;
                                nxt_r.fetch_ready = 1'b0;
                                nxt_r.fsm         = FSM_LOAD_WAIT;
                            end
                            OP_INST3: begin
                                nxt_r.ls_req      = 1'b1;
                                nxt_r.ls_write    = 1'b1;
                                nxt_r.ls_addr     = sif.rd_data[ST13];
                                nxt_r.st_data     = sif.rd_data[ST12];
                                sif.wr_en[ST13]   = 1'b1;
                                sif.wr_data[ST13] = sif.rd_data[ST13] + ADDR_STEP;
                            end
                            default: begin
                                // Nop and base ops: no state, bank or bus effect
                                nxt_r.insn_illegal = 1'b0;
                            end
                        endcase
                    end
                end
            end
            FSM_GR_READ: begin
                // General file answers one cycle after it sees the index
                nxt_r.fsm = FSM_GR_CAP;
            end
            FSM_GR_CAP: begin
                sif.wr_en[r_ff.sidx]   = 1'b1;
                sif.wr_data[r_ff.sidx] = GR_RD_DATA;
                nxt_r.fetch_ready      = 1'b1;
                nxt_r.fsm              = FSM_FETCH;
            end
            FSM_LOAD_WAIT: begin
                // Fetch stalls here; a slow memory only costs cycles
                if (LOAD_RETURN_VALID) begin
                    sif.wr_en[r_ff.load_dst]   = 1'b1;
                    sif.wr_data[r_ff.load_dst] = LOAD_RETURN_DATA;
                    nxt_r.fetch_ready          = 1'b1;
                    nxt_r.fsm                  = FSM_FETCH;
                end
            end
            default: begin
                nxt_r.fsm = FSM_FETCH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign FETCH_READY                = r_ff.fetch_ready;
    assign INSN_VALID                 = r_ff.insn_valid;
    assign INSN_LEN                   = r_ff.len;
    assign INSN_WORD                  = r_ff.insn_word;
    assign INSN_ILLEGAL               = r_ff.insn_illegal;
    assign SLOT_VALID                 = r_ff.slot_valid;
    assign SLOT_OP                    = r_ff.slot_op;
    assign GR_RD_IDX                  = r_ff.gr_rd_idx;
    assign GR_WR_EN                   = r_ff.gr_wr_en;
    assign GR_WR_IDX                  = r_ff.gr_wr_idx;
    assign GR_WR_DATA                 = r_ff.gr_wr_data;
    assign LS_REQ                     = r_ff.ls_req;
    assign LS_WRITE                   = r_ff.ls_write;
    assign LOAD_STORE_VIRTUAL_ADDRESS = r_ff.ls_addr;
    assign STORE_WRITE_DATA           = r_ff.st_data;
endmodule

// file: hdl/mlsd_pkg.sv
package mlsd_pkg;

    // ------------------------------------------------------------
    // Length codes in the first fetched byte, bits [1:0]
    // ------------------------------------------------------------
    localparam logic [1:0] LEN_24  = 2'b00;
    localparam logic [1:0] LEN_16  = 2'b01;
    localparam logic [1:0] LEN_32  = 2'b10;
    localparam logic [1:0] LEN_64  = 2'b11;
    localparam int         LEN_LO  = 0;
    localparam logic [3:0] BYTES_16 = 4'h2;
    localparam logic [3:0] BYTES_24 = 4'h3;
    localparam logic [3:0] BYTES_32 = 4'h4;
    localparam logic [3:0] BYTES_64 = 4'h8;

    // ------------------------------------------------------------
    // 24-bit extension format fields and opcodes
    // ------------------------------------------------------------
    localparam int         OP_LO   = 4;
    localparam int         SIDX_LO = 8;
    localparam int         GR_LO   = 12;
    localparam logic [3:0] OP_NOP         = 4'h0;
    localparam logic [3:0] OP_READ_STATE  = 4'h1;
    localparam logic [3:0] OP_WRITE_STATE = 4'h2;
    localparam logic [3:0] OP_INST1       = 4'h3;
    localparam logic [3:0] OP_INST2       = 4'h4;
    localparam logic [3:0] OP_INST3       = 4'h5;

    // ------------------------------------------------------------
    // Implicit state registers
    // ------------------------------------------------------------
    localparam int          NUM_STATES = 6;
    localparam logic [2:0]  ST8  = 3'h0;
    localparam logic [2:0]  ST9  = 3'h1;
    localparam logic [2:0]  ST10 = 3'h2;
    localparam logic [2:0]  ST11 = 3'h3;
    localparam logic [2:0]  ST12 = 3'h4;
    localparam logic [2:0]  ST13 = 3'h5;
    localparam logic [5:0]  STATE_NARROW = 6'h15;
    localparam logic [31:0] NARROW_MASK  = 32'h0000ffff;
    localparam logic [31:0] ADDR_STEP    = 32'h00000004;
    localparam logic [31:0] STATE_RST    = 32'h00000000;

    // ------------------------------------------------------------
    // Slot layout of the wide formats (opcode is the low nibble)
    // ------------------------------------------------------------
    localparam int NUM_SLOTS = 3;
    localparam int SLOT64_LO [NUM_SLOTS] = '{4, 22, 42};
    localparam int SLOT32_LO [2]         = '{4, 16};
    localparam logic [NUM_SLOTS-1:0][15:0] SLOT64_MASK = {16'h0fff, 16'h00ff, 16'h0039};
    localparam logic [NUM_SLOTS-1:0][15:0] SLOT32_MASK = {16'h0001, 16'h0f0f, 16'h00ff};

    typedef enum logic [1:0] {
        FSM_FETCH,
        FSM_GR_READ,
        FSM_GR_CAP,
        FSM_LOAD_WAIT
    } mlsd_fsm_t;

    typedef struct packed {
        mlsd_fsm_t                       fsm;
        logic [3:0]                      cnt;
        logic [3:0]                      need;
        logic [63:0]                     word;
        logic [1:0]                      len;
        logic [2:0]                      sidx;
        logic [2:0]                      load_dst;
        logic                            fetch_ready;
        logic                            insn_valid;
        logic [63:0]                     insn_word;
        logic                            insn_illegal;
        logic [NUM_SLOTS-1:0]            slot_valid;
        logic [NUM_SLOTS-1:0][3:0]       slot_op;
        logic [3:0]                      gr_rd_idx;
        logic                            gr_wr_en;
        logic [3:0]                      gr_wr_idx;
        logic [31:0]                     gr_wr_data;
        logic                            ls_req;
        logic                            ls_write;
        logic [31:0]                     ls_addr;
        logic [31:0]                     st_data;
    } mlsd_ctl_t;

    typedef struct packed {
        logic [NUM_STATES-1:0][31:0] ent;
    } mlsd_bank_t;

    function automatic logic [3:0] mlsd_len_bytes(input logic [1:0] code);
        case (code)
            LEN_16:  mlsd_len_bytes = BYTES_16;
            LEN_32:  mlsd_len_bytes = BYTES_32;
            LEN_64:  mlsd_len_bytes = BYTES_64;
            default: mlsd_len_bytes = BYTES_24;
        endcase
    endfunction

endpackage

// file: hdl/mlsd_state_if.sv
`timescale 1ns/1ps
interface mlsd_state_if;
    import mlsd_pkg::*;
    logic [NUM_STATES-1:0]       wr_en;
    logic [NUM_STATES-1:0][31:0] wr_data;
    logic [NUM_STATES-1:0][31:0] rd_data;

    modport ctrl (output wr_en, output wr_data, input rd_data);
    modport bank (input wr_en, input wr_data, output rd_data);
endinterface

// file: hdl/mlsd_state_bank.sv
`timescale 1ns/1ps
module mlsd_state_bank (
    input wire logic    clk,
    input wire logic    rst,
    mlsd_state_if.bank  sif
);
    import mlsd_pkg::*;

    mlsd_bank_t bank_ff;
    mlsd_bank_t nxt_bank;

    // Per-entry write; narrow entries drop upper bits so reads stay clean
    always_comb begin
        nxt_bank = bank_ff;
        for (int i = 0; i < NUM_STATES; i++) begin
            if (sif.wr_en[i]) begin
                nxt_bank.ent[i] = STATE_NARROW[i] ? (sif.wr_data[i] & NARROW_MASK)
                                                  : sif.wr_data[i];
            end
        end
    end

    // Entries are the registers themselves, so reads need no extra stage
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_ff <= '0;
        end else begin
            bank_ff <= nxt_bank;
        end
    end

    assign sif.rd_data = bank_ff.ent;
endmodule

// file: sim/mlsd_decoder_sva.sv
`timescale 1ns/1ps
module mlsd_decoder_sva
    import mlsd_pkg::*;
(
    input wire logic                          CLK,
    input wire logic                          SYS_RST,
    input wire logic                          FETCH_READY,
    input wire logic                          INSN_VALID,
    input wire logic [1:0]                    INSN_LEN,
    input wire logic [63:0]                   INSN_WORD,
    input wire logic                          INSN_ILLEGAL,
    input wire logic [NUM_SLOTS-1:0]          SLOT_VALID,
    input wire logic [NUM_SLOTS-1:0][3:0]     SLOT_OP,
    input wire logic                          GR_WR_EN,
    input wire logic                          LS_REQ,
    input wire logic                          LS_WRITE
);
    // ------------------------------------------------------------
    // Decode and side-effect relations
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_len_code: assert property (INSN_VALID |-> INSN_LEN == INSN_WORD[1:0])
        else $error("length code differs from word");
    chk_zero_16: assert property (INSN_VALID && INSN_LEN == LEN_16
        |-> INSN_WORD[63:16] == '0 && SLOT_VALID == '0)
        else $error("16-bit word not clean");
    chk_zero_24: assert property (INSN_VALID && INSN_LEN == LEN_24
        |-> INSN_WORD[63:24] == '0 && SLOT_VALID == '0)
        else $error("24-bit word not clean");
    chk_zero_32: assert property (INSN_VALID && INSN_LEN == LEN_32
        |-> INSN_WORD[63:32] == '0)
        else $error("32-bit word not clean");
    chk_slot_op64: assert property (INSN_VALID && INSN_LEN == LEN_64
        |-> SLOT_OP[0] == INSN_WORD[7:4] && SLOT_OP[1] == INSN_WORD[25:22]
            && SLOT_OP[2] == INSN_WORD[45:42])
        else $error("wide slot opcodes misplaced");
    chk_slot_nop: assert property (INSN_VALID && INSN_LEN == LEN_64 |-> SLOT_VALID ==
        {SLOT_OP[2] != OP_NOP, SLOT_OP[1] != OP_NOP, SLOT_OP[0] != OP_NOP})
        else $error("no-op slot reported active");
    chk_slot_set: assert property (INSN_VALID && INSN_LEN == LEN_64 |-> INSN_ILLEGAL ==
        !(SLOT64_MASK[0][SLOT_OP[0]] && SLOT64_MASK[1][SLOT_OP[1]]
          && SLOT64_MASK[2][SLOT_OP[2]]))
        else $error("slot set check wrong");
    chk_valid_gap: assert property (INSN_VALID |=> !INSN_VALID)
        else $error("instruction reported twice");
    chk_gr_move: assert property (GR_WR_EN |-> INSN_VALID)
        else $error("general write without instruction");
    chk_load_stall: assert property (LS_REQ && !LS_WRITE |=> !FETCH_READY)
        else $error("fetch not held during load");
    chk_ls_pulse: assert property (LS_REQ |=> !LS_REQ)
        else $error("memory request longer than one cycle");
endmodule

bind mlsd_decoder mlsd_decoder_sva mlsd_decoder_sva_i (.CLK(CLK), .SYS_RST(SYS_RST),
    .FETCH_READY(FETCH_READY), .INSN_VALID(INSN_VALID), .INSN_LEN(INSN_LEN),
    .INSN_WORD(INSN_WORD), .INSN_ILLEGAL(INSN_ILLEGAL), .SLOT_VALID(SLOT_VALID),
    .SLOT_OP(SLOT_OP), .GR_WR_EN(GR_WR_EN), .LS_REQ(LS_REQ), .LS_WRITE(LS_WRITE));

// file: sim/mlsd_core_model.sv
`timescale 1ns/1ps
module mlsd_core_model (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [3:0]  lat,
    input  wire logic [3:0]  GR_RD_IDX,
    output logic [31:0]      GR_RD_DATA,
    input  wire logic        LS_REQ,
    input  wire logic        LS_WRITE,
    input  wire logic [31:0] LOAD_STORE_VIRTUAL_ADDRESS,
    input  wire logic [31:0] STORE_WRITE_DATA,
    output logic             LOAD_RETURN_VALID,
    output logic [31:0]      LOAD_RETURN_DATA,
    output logic [31:0]      st_addr,
    output logic [31:0]      st_data
);
    localparam logic [31:0] LD_KEY = 32'h13570000;
    logic        pend = 1'b0;
    logic [3:0]  wcnt = 4'h0;
    logic [31:0] ld_addr = 32'h0;
    logic        fire;

    // General registers: value follows the index, so a wrong index shows
    assign GR_RD_DATA = 32'hc0de0000 | {28'h0, GR_RD_IDX};
    initial begin
        LOAD_RETURN_VALID = 1'b0;
        LOAD_RETURN_DATA  = 32'h0;
        st_addr = 32'h0;
        st_data = 32'h0;
    end

    // Memory side on the falling edge; data toggles when not valid
    always @(negedge CLK) begin
        fire = !SYS_RST && !LS_REQ && pend && wcnt == 4'h0;
        LOAD_RETURN_VALID <= fire;
        LOAD_RETURN_DATA  <= fire ? (ld_addr ^ LD_KEY) : ~LOAD_RETURN_DATA;
        if (SYS_RST) pend <= 1'b0;
        else if (LS_REQ && LS_WRITE) begin
            st_addr <= LOAD_STORE_VIRTUAL_ADDRESS;
            st_data <= STORE_WRITE_DATA;
        end else if (LS_REQ) begin
            pend    <= 1'b1;
            wcnt    <= lat;
            ld_addr <= LOAD_STORE_VIRTUAL_ADDRESS;
        end else if (fire) begin
            pend <= 1'b0;
        end else if (pend) wcnt <= wcnt - 4'h1;
    end
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module testbench;
    import mlsd_pkg::*;
    typedef struct packed { logic [63:0] w; logic [2:0] sv; logic ill; } mlsd_row_t;
    logic clk, sys_rst, fetch_valid, fetch_ready, insn_valid, insn_illegal;
    logic gr_wr_en, ls_req, ls_write, ld_valid;
    logic [7:0] fetch_byte;
    logic [3:0] lat, gr_rd_idx, gr_wr_idx;
    logic [1:0] insn_len;
    logic [63:0] insn_word;
    logic [2:0] slot_valid;
    logic [2:0][3:0] slot_op;
    logic [31:0] gr_rd_data, gr_wr_data, ls_addr, st_wdata, ld_data, st_addr, st_data;
    logic [32:0] ls_last = 33'h0;
    logic [69:0] got_q[$];
    logic [35:0] gw_q[$];
    int errors = 0;
    int checks = 0;
    // Mixed lengths, legal and illegal slot mixes
    mlsd_row_t rows [7] = '{'{64'h000000000000a561, 3'b000, 1'b0},
        '{64'h00000000003c0560, 3'b000, 1'b0}, '{64'h0000000000000610, 3'b000, 1'b1},
        '{64'h0000000000090072, 3'b011, 1'b0}, '{64'h0000000000040072, 3'b011, 1'b1},
        '{64'h0000000001c00033, 3'b011, 1'b0}, '{64'h00002c0000000013, 3'b101, 1'b1}};
    logic [35:0] exp_gw [8] = '{{4'h5, 32'hc0de0003}, {4'h2, 32'h00000007},
        {4'h1, 32'hc0de0007}, {4'h1, 32'h00000003}, {4'h5, 32'h00000004},
        {4'h6, 32'h00000009}, {4'h4, 32'h00000003}, {4'h3, 32'hc0de000d}};
    logic [69:0] exp_row;

    mlsd_decoder mlsd_decoder_i (.CLK(clk), .SYS_RST(sys_rst), .FETCH_VALID(fetch_valid),
        .FETCH_BYTE(fetch_byte), .FETCH_READY(fetch_ready), .INSN_VALID(insn_valid),
        .INSN_LEN(insn_len), .INSN_WORD(insn_word), .INSN_ILLEGAL(insn_illegal),
        .SLOT_VALID(slot_valid), .SLOT_OP(slot_op), .GR_RD_IDX(gr_rd_idx),
        .GR_RD_DATA(gr_rd_data), .GR_WR_EN(gr_wr_en), .GR_WR_IDX(gr_wr_idx),
        .GR_WR_DATA(gr_wr_data), .LS_REQ(ls_req), .LS_WRITE(ls_write),
        .LOAD_STORE_VIRTUAL_ADDRESS(ls_addr), .STORE_WRITE_DATA(st_wdata),
        .LOAD_RETURN_VALID(ld_valid), .LOAD_RETURN_DATA(ld_data));
    mlsd_core_model mlsd_core_model_i (.CLK(clk), .SYS_RST(sys_rst), .lat(lat),
        .GR_RD_IDX(gr_rd_idx), .GR_RD_DATA(gr_rd_data), .LS_REQ(ls_req), .LS_WRITE(ls_write),
        .LOAD_STORE_VIRTUAL_ADDRESS(ls_addr), .STORE_WRITE_DATA(st_wdata),
        .LOAD_RETURN_VALID(ld_valid), .LOAD_RETURN_DATA(ld_data), .st_addr(st_addr),
        .st_data(st_data));

    // ------------------------------------------------------------
    // Clock, helpers, monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic int nbytes(logic [1:0] c);
        case (c)
            2'b01:   return 2;
            2'b10:   return 4;
            2'b11:   return 8;
            default: return 3;
        endcase
    endfunction
    // Byte held until a falling edge sees ready, so it is taken next rise
    task automatic send(input logic [63:0] w);
        for (int k = 0; k < nbytes(w[1:0]); k++) begin
            @(negedge clk);
            fetch_valid = 1'b1;
            fetch_byte  = w[8*k +: 8];
            while (fetch_ready !== 1'b1) @(negedge clk);
        end
    endtask
    task automatic idle(input int n);
        @(negedge clk);
        fetch_valid = 1'b0;
        fetch_byte  = ~fetch_byte;
        repeat (n) @(negedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Record results at the rise; outputs still show the previous cycle
    always @(posedge clk) begin
        if (insn_valid === 1'b1) got_q.push_back({insn_illegal, slot_valid, insn_len, insn_word});
        if (gr_wr_en === 1'b1) gw_q.push_back({gr_wr_idx, gr_wr_data});
        if (ls_req === 1'b1) ls_last <= {ls_write, ls_addr};
    end
    // Hang guard, far beyond the roughly 120 cycles of the run
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
        lat = 4'h0;
        repeat (12) @(negedge clk);
        `CHK("ready_in_reset", 1'b0, fetch_ready)
        `CHK("ls_req_in_reset", 1'b0, ls_req)
        sys_rst = 1'b0;
        foreach (rows[i]) send(rows[i].w);
        idle(4);
        `CHK("insn_count", 7, got_q.size())
        foreach (rows[i]) begin
            exp_row = {rows[i].ill, rows[i].sv, rows[i].w[1:0], rows[i].w};
            `CHK("insn", exp_row, got_q[i])
        end
        `CHK("slot_op", 12'hb01, slot_op)
        gw_q.delete();
        // Moves back to back: write stalls, the following read waits
        send(64'h003120);
        send(64'h005110);
        send(64'h007020);
        send(64'h002010);
        lat = 4'h3;
        send(64'h000030);
        idle(2);
        `CHK("load_addr", {1'b0, 32'hc0de0003}, ls_last)
        send(64'h001110);
        send(64'h001010);
        send(64'h000050);
        idle(2);
        `CHK("store_addr", {1'b1, 32'h0}, ls_last)
        `CHK("store_data", 32'h00000007, st_data)
        `CHK("store_mem_addr", 32'h0, st_addr)
        send(64'h005510);
        // Second custom load: halves state12, loads into state10
        send(64'h009320);
        send(64'h000040);
        send(64'h006210);
        send(64'h004410);
        send(64'h003310);
        idle(6);
        `CHK("load2_addr", {1'b0, 32'hc0de0009}, ls_last)
        `CHK("move_count", 8, gw_q.size())
        foreach (exp_gw[i]) `CHK("gr_move", exp_gw[i], gw_q[i])
        summarize;
    end
endmodule
